// *** shared/cpt_pkg.sv ***
// Purpose: Constants and types for the preview timing block
// Assumes: Byte wide register port, one pixel clock
// Notes: Reserved register bits read as zero
package cpt_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_EXTRA_HI = 8'h23;
  localparam logic [7:0] ADDR_EXTRA_LO = 8'h24;
  localparam logic [7:0] ADDR_MODE = 8'h25;
  localparam logic [7:0] ADDR_NINT_LO = 8'h26;
  localparam logic [7:0] ADDR_POL = 8'h28;
  localparam logic [7:0] ADDR_HCLK1 = 8'h29;
  localparam logic [7:0] ADDR_HCLK2 = 8'h2a;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [7:0] RST_EXTRA_HI = 8'h00;
  localparam logic [7:0] RST_EXTRA_LO = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h01;
  localparam logic [7:0] RST_NINT_LO = 8'h06;
  localparam logic [7:0] RST_POL = 8'hff;
  localparam logic [7:0] RST_HCLK1 = 8'h68;
  localparam logic [7:0] RST_HCLK2 = 8'h7a;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int EXTRA_HI_W = 3;
  localparam int MODE_VSEL_BIT = 5;
  localparam int MODE_SUM_LSB = 1;
  localparam int MODE_SUM_MSB = 4;
  localparam int MODE_NINT_MSB_BIT = 0;
  localparam int HCLK_CFG_MSB = 6;

  // ----------------------------------------
  // Counts
  // ----------------------------------------
  localparam int READOUT_LINES = 262;
  localparam int LINE_PIXELS = 64;
  localparam logic [2:0] SLOTS_LAST = 3'h7;
  localparam logic [2:0] UNIT_LAST = 3'h4;
  localparam logic [2:0] PHASE_HALF = 3'h4;
  localparam logic [2:0] TAP_LAST = 3'h7;
  localparam int PIXEL_CLKS = 8;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic hold;
    logic [2:0] fall;
    logic [2:0] rise;
  } cpt_hclk_s;

  typedef struct packed {
    logic [10:0] extra;
    logic vsel;
    logic [3:0] sum;
    logic [8:0] nint;
    logic [7:0] pol;
    cpt_hclk_s h1;
    cpt_hclk_s h2;
  } cpt_cfg_s;

  typedef enum logic [1:0] {
    ST_TRANSFER,
    ST_VSHIFT,
    ST_HORIZ,
    ST_EXTRA
  } cpt_state_e;

endpackage

// *** hw/cpt_hclk_gen.sv ***
// Purpose: One horizontal clock built from phase tap edges
// Assumes: Taps change once per system clock
// Notes: Rise wins when both edges select the same tap
`timescale 1ns/1ps
module cpt_hclk_gen (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Timing
  input wire logic [7:0] tap_i,
  input wire logic run_i,
  input wire cpt_pkg::cpt_hclk_s cfg_i,
  // Output
  output logic hclk_o
);

  logic [7:0] tap_q;
  logic [7:0] tap_rise;
  logic hclk_q;

  assign tap_rise = tap_i & ~tap_q;
  assign hclk_o = hclk_q;

  // ----------------------------------------
  // Edge tracking
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tap_q <= 8'h00;
    end else begin
      tap_q <= tap_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hclk_q <= 1'b0;
    end else if (!run_i) begin
      hclk_q <= cfg_i.hold;
    end else if (tap_rise[cfg_i.rise]) begin
      hclk_q <= 1'b1;
    end else if (tap_rise[cfg_i.fall]) begin
      hclk_q <= 1'b0;
    end
  end

  a_hold_idle: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !run_i |=> hclk_o == $past(cfg_i.hold))
    else $error("Hold level not kept outside line");

endmodule

// *** hw/cpt_preview_timing.sv ***
// Purpose: Preview mode vertical and horizontal timing
// Assumes: Register port already deserialised, pixel clock only
// Notes: Frames repeat without end; one pixel is eight clocks
`timescale 1ns/1ps
module cpt_preview_timing #(
  parameter int READOUT_LINES = cpt_pkg::READOUT_LINES,
  parameter int LINE_PIXELS = cpt_pkg::LINE_PIXELS
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Slot width in pixel clocks
  input wire logic [4:0] slot_width_i,
  // Sensor clocks
  output logic [7:0] vshift_o,
  output logic [1:0] hclk_o,
  output logic strobe_o,
  output logic exposing_o
);

  cpt_pkg::cpt_cfg_s cfg_q;
  cpt_pkg::cpt_state_e state_q;
  logic [7:0] rdata_q;
  logic [4:0] slot_cnt_q;
  logic [2:0] slot_idx_q;
  logic [2:0] unit_q;
  logic [8:0] line_q;
  logic [2:0] step_q;
  logic [11:0] pix_q;
  logic [15:0] tmr_q;
  logic [10:0] ext_q;
  logic [7:0] vshift_q;
  logic strobe_q;
  logic exposing_q;
  logic [4:0] sw;
  logic vert, slot_tick, row_end, pix_end, line_last, ext_tick;
  logic [15:0] line_clks;
  logic [8:0] nint_eff;
  logic [3:0] vph;
  logic [7:0] pulse;
  logic [7:0] tap;
  logic v_on, s_on, s1_on, sum_en;

  assign reg_rdata_o = rdata_q;
  assign vshift_o = vshift_q;
  assign strobe_o = strobe_q;
  assign exposing_o = exposing_q;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_q.extra <= {cpt_pkg::RST_EXTRA_HI[2:0], cpt_pkg::RST_EXTRA_LO};
      cfg_q.vsel <= cpt_pkg::RST_MODE[cpt_pkg::MODE_VSEL_BIT];
      cfg_q.sum <= cpt_pkg::RST_MODE[cpt_pkg::MODE_SUM_MSB:
                                     cpt_pkg::MODE_SUM_LSB];
      cfg_q.nint <= {cpt_pkg::RST_MODE[cpt_pkg::MODE_NINT_MSB_BIT],
                     cpt_pkg::RST_NINT_LO};
      cfg_q.pol <= cpt_pkg::RST_POL;
      cfg_q.h1 <= cpt_pkg::RST_HCLK1[cpt_pkg::HCLK_CFG_MSB:0];
      cfg_q.h2 <= cpt_pkg::RST_HCLK2[cpt_pkg::HCLK_CFG_MSB:0];
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        cpt_pkg::ADDR_EXTRA_HI: begin
          cfg_q.extra[10:8] <= reg_wdata_i[2:0];
        end
        cpt_pkg::ADDR_EXTRA_LO: begin
          cfg_q.extra[7:0] <= reg_wdata_i;
        end
        cpt_pkg::ADDR_MODE: begin
          cfg_q.vsel <= reg_wdata_i[cpt_pkg::MODE_VSEL_BIT];
          cfg_q.sum <= reg_wdata_i[cpt_pkg::MODE_SUM_MSB:
                                   cpt_pkg::MODE_SUM_LSB];
          cfg_q.nint[8] <= reg_wdata_i[cpt_pkg::MODE_NINT_MSB_BIT];
        end
        cpt_pkg::ADDR_NINT_LO: begin
          cfg_q.nint[7:0] <= reg_wdata_i;
        end
        cpt_pkg::ADDR_POL: begin
          cfg_q.pol <= reg_wdata_i;
        end
        cpt_pkg::ADDR_HCLK1: begin
          cfg_q.h1 <= reg_wdata_i[cpt_pkg::HCLK_CFG_MSB:0];
        end
        cpt_pkg::ADDR_HCLK2: begin
          cfg_q.h2 <= reg_wdata_i[cpt_pkg::HCLK_CFG_MSB:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
    end else begin
      case (reg_addr_i)
        cpt_pkg::ADDR_EXTRA_HI: rdata_q <= {5'h00, cfg_q.extra[10:8]};
        cpt_pkg::ADDR_EXTRA_LO: rdata_q <= cfg_q.extra[7:0];
        cpt_pkg::ADDR_MODE: begin
          rdata_q <= {2'h0, cfg_q.vsel, cfg_q.sum, cfg_q.nint[8]};
        end
        cpt_pkg::ADDR_NINT_LO: rdata_q <= cfg_q.nint[7:0];
        cpt_pkg::ADDR_POL: rdata_q <= cfg_q.pol;
        cpt_pkg::ADDR_HCLK1: rdata_q <= {1'b0, cfg_q.h1};
        cpt_pkg::ADDR_HCLK2: rdata_q <= {1'b0, cfg_q.h2};
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Timing terms
  // ----------------------------------------
  assign sw = (slot_width_i == 5'h00) ? 5'h01 : slot_width_i;
  assign vert = (state_q == cpt_pkg::ST_TRANSFER) ||
                (state_q == cpt_pkg::ST_VSHIFT);
  assign slot_tick = vert && (slot_cnt_q >= sw - 5'h01);
  assign row_end = slot_tick && (slot_idx_q == cpt_pkg::SLOTS_LAST);
  assign line_last = (line_q == 9'(READOUT_LINES - 1));
  assign pix_end = (state_q == cpt_pkg::ST_HORIZ) &&
                   (step_q == cpt_pkg::TAP_LAST) &&
                   (pix_q == 12'(LINE_PIXELS - 1));
  assign line_clks = {8'h00, sw, 3'h0} +
                     16'(LINE_PIXELS * cpt_pkg::PIXEL_CLKS);
  assign ext_tick = (state_q == cpt_pkg::ST_EXTRA) &&
                    (tmr_q >= line_clks - 16'h0001);
  assign nint_eff = (cfg_q.nint > 9'(READOUT_LINES)) ?
                    9'(READOUT_LINES) : cfg_q.nint;

  // ----------------------------------------
  // Frame sequence
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= cpt_pkg::ST_TRANSFER;
    end else begin
      case (state_q)
        cpt_pkg::ST_TRANSFER: begin
          if (row_end && unit_q == cpt_pkg::UNIT_LAST && line_last) begin
            state_q <= cpt_pkg::ST_VSHIFT;
          end
        end
        cpt_pkg::ST_VSHIFT: begin
          if (row_end) begin
            state_q <= cpt_pkg::ST_HORIZ;
          end
        end
        cpt_pkg::ST_HORIZ: begin
          if (pix_end) begin
            if (!line_last) begin
              state_q <= cpt_pkg::ST_VSHIFT;
            end else if (cfg_q.extra == 11'h000) begin
              state_q <= cpt_pkg::ST_TRANSFER;
            end else begin
              state_q <= cpt_pkg::ST_EXTRA;
            end
          end
        end
        cpt_pkg::ST_EXTRA: begin
          if (ext_tick && (ext_q + 11'h001) >= cfg_q.extra) begin
            state_q <= cpt_pkg::ST_TRANSFER;
          end
        end
        default: state_q <= cpt_pkg::ST_TRANSFER;
      endcase
    end
  end

  // ----------------------------------------
  // Slot counters
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      slot_cnt_q <= 5'h00;
      slot_idx_q <= 3'h0;
    end else if (!vert) begin
      slot_cnt_q <= 5'h00;
      slot_idx_q <= 3'h0;
    end else if (slot_tick) begin
      slot_cnt_q <= 5'h00;
      slot_idx_q <= slot_idx_q + 3'h1;
    end else begin
      slot_cnt_q <= slot_cnt_q + 5'h01;
    end
  end

  // ----------------------------------------
  // Line and unit counters
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      unit_q <= 3'h0;
    end else if (state_q != cpt_pkg::ST_TRANSFER) begin
      unit_q <= 3'h0;
    end else if (row_end) begin
      unit_q <= (unit_q == cpt_pkg::UNIT_LAST) ? 3'h0 : unit_q + 3'h1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      line_q <= 9'h000;
    end else if ((state_q == cpt_pkg::ST_TRANSFER && row_end &&
                  unit_q == cpt_pkg::UNIT_LAST) || pix_end) begin
      line_q <= line_last ? 9'h000 : line_q + 9'h001;
    end
  end

  // ----------------------------------------
  // Pixel and extra line counters
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      step_q <= 3'h0;
      pix_q <= 12'h000;
    end else if (state_q != cpt_pkg::ST_HORIZ) begin
      step_q <= 3'h0;
      pix_q <= 12'h000;
    end else begin
      step_q <= step_q + 3'h1;
      if (step_q == cpt_pkg::TAP_LAST) begin
        pix_q <= pix_end ? 12'h000 : pix_q + 12'h001;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tmr_q <= 16'h0000;
      ext_q <= 11'h000;
    end else if (state_q != cpt_pkg::ST_EXTRA) begin
      tmr_q <= 16'h0000;
      ext_q <= 11'h000;
    end else if (ext_tick) begin
      tmr_q <= 16'h0000;
      ext_q <= ext_q + 11'h001;
    end else begin
      tmr_q <= tmr_q + 16'h0001;
    end
  end

  // ----------------------------------------
  // Vertical pulses
  // ----------------------------------------
  assign v_on = (state_q == cpt_pkg::ST_TRANSFER) &&
                (unit_q != cpt_pkg::UNIT_LAST);
  assign s_on = (state_q == cpt_pkg::ST_VSHIFT) ||
                (state_q == cpt_pkg::ST_TRANSFER && unit_q == 3'h0);
  assign sum_en = (state_q == cpt_pkg::ST_TRANSFER) && (unit_q != 3'h0) &&
                  cfg_q.sum[2'(cpt_pkg::UNIT_LAST - unit_q)];
  assign s1_on = s_on || sum_en;

  generate
    for (genvar k = 0; k < 4; k++) begin : g_vphase
      assign vph[k] = (3'(slot_idx_q - 3'(2 * k)) < cpt_pkg::PHASE_HALF);
      assign pulse[7 - k] = v_on && vph[k];
      if (k == 0) begin : g_s1
        assign pulse[3] = s1_on && vph[0];
      end else begin : g_sn
        assign pulse[3 - k] = s_on && vph[k];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      vshift_q <= ~cpt_pkg::RST_POL;
    end else begin
      vshift_q <= (pulse & cfg_q.pol) | (~pulse & ~cfg_q.pol);
    end
  end

  // ----------------------------------------
  // Strobe and exposure
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strobe_q <= 1'b0;
      exposing_q <= 1'b0;
    end else begin
      strobe_q <= cfg_q.vsel ? (state_q == cpt_pkg::ST_TRANSFER) :
                               (state_q == cpt_pkg::ST_HORIZ);
      exposing_q <= (state_q == cpt_pkg::ST_EXTRA) ||
                    (!vert || state_q == cpt_pkg::ST_VSHIFT) &&
                    (line_q >= 9'(READOUT_LINES) - nint_eff);
    end
  end

  // ----------------------------------------
  // Horizontal clocks
  // ----------------------------------------
  generate
    for (genvar k = 0; k < 8; k++) begin : g_tap
      assign tap[k] = (3'(step_q - 3'(k)) < cpt_pkg::PHASE_HALF);
    end
    for (genvar c = 0; c < 2; c++) begin : g_hclk
      cpt_hclk_gen u_gen (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .tap_i(tap),
        .run_i(state_q == cpt_pkg::ST_HORIZ),
        .cfg_i(c == 0 ? cfg_q.h1 : cfg_q.h2),
        .hclk_o(hclk_o[c])
      );
    end
  endgenerate

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_strobe_select: assert property (
    $stable(cfg_q.vsel) |=> strobe_o == ($past(cfg_q.vsel) ?
      $past(state_q) == cpt_pkg::ST_TRANSFER :
      $past(state_q) == cpt_pkg::ST_HORIZ))
    else $error("Strobe pin source wrong");
  a_first_pulse: assert property (
    (state_q == cpt_pkg::ST_TRANSFER && unit_q == 3'h0 &&
     slot_idx_q == 3'h0) |=> vshift_o[3] == $past(cfg_q.pol[3]))
    else $error("First storage pulse missing");
  a_sum_off: assert property (
    (state_q == cpt_pkg::ST_TRANSFER && unit_q == cpt_pkg::UNIT_LAST &&
     !cfg_q.sum[0]) |=> vshift_o[3] == ~$past(cfg_q.pol[3]))
    else $error("Unrequested summing pulse");
  a_row_slots: assert property (
    slot_tick |=> slot_idx_q == 3'($past(slot_idx_q) + 3'h1))
    else $error("Slot index did not advance");
  a_unit_range: assert property (
    unit_q <= cpt_pkg::UNIT_LAST)
    else $error("Transfer unit out of range");
  a_int_clamp: assert property (
    nint_eff <= 9'(READOUT_LINES) && nint_eff <= cfg_q.nint)
    else $error("Integration count not clamped");
  a_frame_loop: assert property (
    (pix_end && line_last && cfg_q.extra == 11'h000) |=>
    state_q == cpt_pkg::ST_TRANSFER)
    else $error("Frame did not restart");
  a_extra_expose: assert property (
    (state_q == cpt_pkg::ST_EXTRA) |=> exposing_o)
    else $error("Extra line not exposing");
  a_horiz_idle: assert property (
    (state_q == cpt_pkg::ST_HORIZ && $stable(cfg_q.pol)) |=>
    vshift_o == ~$past(cfg_q.pol))
    else $error("Vertical pulse during line readout");
  a_hclk_rise: assert property (
    (state_q == cpt_pkg::ST_HORIZ && $past(state_q) == cpt_pkg::ST_HORIZ &&
     step_q == cfg_q.h1.rise && $stable(cfg_q.h1)) |=> hclk_o[0])
    else $error("Horizontal clock one did not rise");

endmodule

// *** tb/cpt_sensor_model.sv ***
// Purpose: Sensor side model counting vertical clock pulses
// Assumes: Active level of each vertical output is its polarity bit
// Notes: Counters run free; the bench takes differences
`timescale 1ns/1ps
module cpt_sensor_model (
  // Clock
  input wire logic sys_clk_i,
  // Sensor clocks and expected active levels
  input wire logic [7:0] vshift_i,
  input wire logic [7:0] pol_i,
  // Pulse counts
  output logic [15:0] v1_cnt_o,
  output logic [15:0] s1_cnt_o
);
  logic [7:0] act_q = 8'h00;
  logic [7:0] act_d;
  logic [15:0] v1_q = 16'h0000;
  logic [15:0] s1_q = 16'h0000;

  assign v1_cnt_o = v1_q;
  assign s1_cnt_o = s1_q;

  // ----------------------------------------
  // Active phases and their leading edges
  // ----------------------------------------
  assign act_d = ~(vshift_i ^ pol_i);

  always @(posedge sys_clk_i) begin
    if (act_d[7] && !act_q[7]) begin
      v1_q <= v1_q + 16'h0001;
    end
    if (act_d[3] && !act_q[3]) begin
      s1_q <= s1_q + 16'h0001;
    end
    act_q <= act_d;
  end
endmodule

// *** tb/cpt_preview_timing_tb.sv ***
// Purpose: Self-checking bench for the preview timing block
// Assumes: Short frames, slot width one clock
// Notes: Counts are taken over whole frame periods
`timescale 1ns/1ps
module cpt_preview_timing_tb;
  localparam int RL = 4;
  localparam int LP = 2;
  localparam int LN = 8 + LP * 8;
  localparam int FR = RL * 40 + RL * LN;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] pol = 8'hff;
  logic [4:0] slot_w = 5'h01;
  logic [7:0] reg_rdata_o;
  logic [7:0] vshift_o;
  logic [1:0] hclk_o;
  logic strobe_o;
  logic exposing_o;
  logic [15:0] v1_cnt;
  logic [15:0] s1_cnt;
  logic [15:0] v1_0;
  logic [15:0] s1_0;
  int n_errors = 0;
  int n_compared = 0;
  int c_st;
  int c_ex;
  int c_h1;
  int c_h2;

  // ----------------------------------------
  // Design and sensor
  // ----------------------------------------
  cpt_preview_timing #(.READOUT_LINES(RL), .LINE_PIXELS(LP)) dut_u (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .slot_width_i(slot_w),
    .vshift_o(vshift_o),
    .hclk_o(hclk_o),
    .strobe_o(strobe_o),
    .exposing_o(exposing_o)
  );

  cpt_sensor_model sensor_u (
    .sys_clk_i(sys_clk_i),
    .vshift_i(vshift_o),
    .pol_i(pol),
    .v1_cnt_o(v1_cnt),
    .s1_cnt_o(s1_cnt)
  );

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    #1;
    d = reg_rdata_o;
  endtask

  // Settle two periods, then count over one period of n clocks
  task automatic meas(input int n);
    repeat (2 * n) @(posedge sys_clk_i);
    #1;
    c_st = 0;
    c_ex = 0;
    c_h1 = 0;
    c_h2 = 0;
    v1_0 = v1_cnt;
    s1_0 = s1_cnt;
    repeat (n) begin
      @(posedge sys_clk_i);
      #1;
      c_st += (strobe_o === 1'b1);
      c_ex += (exposing_o === 1'b1);
      c_h1 += (hclk_o[0] === 1'b1);
      c_h2 += (hclk_o[1] === 1'b1);
    end
  endtask

  task automatic close_out;
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [7:0] ad [8] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28,
                          8'h29, 8'h2a};
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h01, 8'h06, 8'h00, 8'hff,
                          8'h68, 8'h7a};
    logic [7:0] mk [8] = '{8'h07, 8'hff, 8'h3f, 8'hff, 8'h00, 8'hff,
                          8'h7f, 8'h7f};
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      rd(ad[i], d);
      chk("reset value", {8'h00, rv[i]}, {8'h00, d});
    end
    for (int i = 0; i < 8; i++) begin
      wr(ad[i], 8'hff);
      rd(ad[i], d);
      chk("write mask", {8'h00, mk[i]}, {8'h00, d});
      wr(ad[i], rv[i]);
    end
  endtask

  task automatic t_strobe;
    meas(FR);
    chk("strobe readout", 16'(RL * LP * 8), 16'(c_st));
    wr(8'h25, 8'h21);
    meas(FR);
    chk("strobe vsync", 16'(RL * 40), 16'(c_st));
    wr(8'h25, 8'h01);
  endtask

  // Wider slots stretch transfer and vertical shift time
  task automatic t_slot;
    wr(8'h25, 8'h21);
    slot_w <= 5'h02;
    meas(FR + RL * 48);
    chk("slot two transfer", 16'(RL * 80), 16'(c_st));
    chk("slot two exposure", 16'(RL * 32), 16'(c_ex));
    slot_w <= 5'h00;
    meas(FR);
    chk("slot zero transfer", 16'(RL * 40), 16'(c_st));
    slot_w <= 5'h01;
    wr(8'h25, 8'h01);
  endtask

  task automatic t_sum;
    // Patterns for no sum, one, two and all four summing bits
    logic [3:0] cd [7] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1, 4'h5, 4'hf};
    for (int i = 0; i < 7; i++) begin
      wr(8'h25, {3'b000, cd[i], 1'b1});
      meas(FR);
      chk("s1 pulses", 16'(RL * (2 + $countones(cd[i]))),
          s1_cnt - s1_0);
      chk("v1 pulses", 16'(RL * 4), v1_cnt - v1_0);
    end
    wr(8'h25, 8'h01);
  endtask

  task automatic t_pol;
    wr(8'h28, 8'h77);
    pol <= 8'h77;
    meas(FR);
    chk("v1 low pulses", 16'(RL * 4), v1_cnt - v1_0);
    chk("s1 low pulses", 16'(RL * 2), s1_cnt - s1_0);
    wr(8'h28, 8'hff);
    pol <= 8'hff;
  endtask

  task automatic t_hclk;
    wr(8'h29, 8'h29);
    wr(8'h2a, 8'h3a);
    meas(FR);
    chk("hclk1 high", 16'(RL * LP * 4), 16'(c_h1));
    chk("hclk2 high", 16'(RL * LP * 5), 16'(c_h2));
    wr(8'h29, 8'h5b);
    wr(8'h2a, 8'h5b);
    meas(FR);
    chk("hclk1 hold", 16'(FR), 16'(c_h1));
    chk("hclk2 hold", 16'(FR), 16'(c_h2));
    wr(8'h29, 8'h68);
    wr(8'h2a, 8'h7a);
  endtask

  task automatic t_expose;
    logic [8:0] ni [6] = '{9'd262, 9'd2, 9'd2, 9'd0, 9'd511, 9'd1};
    logic [10:0] ex [6] = '{11'd0, 11'd0, 11'd3, 11'd0, 11'd1, 11'h100};
    int lines;
    for (int i = 0; i < 6; i++) begin
      wr(8'h23, {5'h00, ex[i][10:8]});
      wr(8'h24, ex[i][7:0]);
      wr(8'h25, {7'h00, ni[i][8]});
      wr(8'h26, ni[i][7:0]);
      lines = (int'(ni[i]) > RL) ? RL : int'(ni[i]);
      meas(FR + LN * int'(ex[i]));
      chk("exposure", 16'(LN * (lines + int'(ex[i]))),
          16'(c_ex));
    end
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk_i);
    chk("outputs in reset", 16'h0000,
        {vshift_o, 4'h0, hclk_o, strobe_o, exposing_o});
    sys_rst_i <= 1'b0;
    t_regs();
    t_strobe();
    t_slot();
    t_sum();
    t_pol();
    t_hclk();
    t_expose();
    close_out();
  end

  initial begin
    #(90000 * 10);
    n_errors++;
    close_out();
  end
endmodule
